// *** logic/pbcr_pkg.sv ***
// package with constants for the phy basic control register block
package pbcr_pkg;
  localparam int unsigned PBCR_DATA_W = 16;
  localparam int unsigned PBCR_IDX_W = 5;
  localparam int unsigned PBCR_PHYAD_W = 5;
  localparam logic [4:0] PBCR_IDX_BASE_CTRL = 5'h00;
  localparam int unsigned PBCR_BIT_SRST = 15;
  localparam int unsigned PBCR_BIT_LOOP = 14;
  localparam int unsigned PBCR_BIT_SPEED = 13;
  localparam int unsigned PBCR_BIT_AN = 12;
  localparam int unsigned PBCR_BIT_PDN = 11;
  localparam int unsigned PBCR_BIT_RSTAN = 9;
  localparam int unsigned PBCR_BIT_DUPLEX = 8;
  localparam int unsigned PBCR_BIT_COLTST = 7;
  localparam logic [15:0] PBCR_WR_MASK = 16'hFB80;
  localparam logic [15:0] PBCR_RESET_FIXED = 16'h0000;
  localparam logic [1:0] PBCR_ST_START = 2'b01;
  localparam logic [1:0] PBCR_OP_WRITE = 2'b01;
  localparam logic [1:0] PBCR_OP_READ = 2'b10;
  localparam logic [1:0] PBCR_TA_WRITE = 2'b10;
  localparam int unsigned PBCR_MDIO_OUT_DLY = 2;
endpackage : pbcr_pkg

// *** logic/pbcr_sync.sv ***
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pbcr_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule : pbcr_sync

// *** logic/pbcr_mdio_slave.sv ***
// serial management frame slave on mdc/mdio
`timescale 1ns/1ps
module pbcr_mdio_slave
  import pbcr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [PBCR_PHYAD_W-1:0] phy_addr_i,
  input wire logic mdc_s_i,
  input wire logic mdio_s_i,
  output logic mdio_o,
  output logic mdio_oe_o,
  output logic wr_o,
  output logic rd_o,
  output logic [PBCR_IDX_W-1:0] idx_o,
  output logic [PBCR_DATA_W-1:0] wdata_o,
  input wire logic [PBCR_DATA_W-1:0] rdata_i
);
  typedef enum logic [2:0] {PBCR_IDLE, PBCR_HDR, PBCR_TA, PBCR_DATA} pbcr_state_e;
  pbcr_state_e state_q;
  logic mdc_q;
  logic rise;
  logic [5:0] ones_q;
  logic [3:0] cnt_q;
  logic [13:0] hdr_q;
  logic [15:0] sh_q;
  logic is_rd_q;
  logic mine_q;
  logic [PBCR_MDIO_OUT_DLY:0] dly_q;
  logic [15:0] out_q;
  logic oe_q;
  logic [13:0] hdr_n;

  assign rise = mdc_s_i & ~mdc_q;
  assign hdr_n = {hdr_q[12:0], mdio_s_i};

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) mdc_q <= 1'b0;
    else mdc_q <= mdc_s_i;
  end

  // frame parser, sampled on mdc rising edges
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_q <= PBCR_IDLE;
      ones_q <= '0;
      cnt_q <= '0;
      hdr_q <= '0;
      sh_q <= '0;
      is_rd_q <= 1'b0;
      mine_q <= 1'b0;
      wr_o <= 1'b0;
      rd_o <= 1'b0;
      idx_o <= '0;
      wdata_o <= '0;
    end else begin
      wr_o <= 1'b0;
      rd_o <= 1'b0;
      if (rise) begin
        case (state_q)
          PBCR_IDLE: begin
            if (mdio_s_i) begin
              if (ones_q != 6'h3f) ones_q <= ones_q + 6'h01;
            end else begin
              if (ones_q == 6'h3f) begin
                state_q <= PBCR_HDR;
                hdr_q <= 14'h0000;
                cnt_q <= 4'h0;
              end
              ones_q <= '0;
            end
          end
          PBCR_HDR: begin
            hdr_q <= hdr_n;
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == 4'hc) begin
              // hdr_n holds st(low bit), op, phyad, regad
              is_rd_q <= (hdr_n[11:10] == PBCR_OP_READ);
              mine_q <= (hdr_n[9:5] == phy_addr_i) && (hdr_n[12] == PBCR_ST_START[0])
                && ((hdr_n[11:10] == PBCR_OP_READ) || (hdr_n[11:10] == PBCR_OP_WRITE));
              idx_o <= hdr_n[4:0];
              rd_o <= (hdr_n[9:5] == phy_addr_i) && (hdr_n[11:10] == PBCR_OP_READ);
              state_q <= PBCR_TA;
              cnt_q <= 4'h0;
            end
          end
          PBCR_TA: begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == 4'h1) begin
              state_q <= PBCR_DATA;
              cnt_q <= 4'h0;
            end
          end
          PBCR_DATA: begin
            sh_q <= {sh_q[14:0], mdio_s_i};
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == 4'hf) begin
              state_q <= PBCR_IDLE;
              wr_o <= mine_q & ~is_rd_q;
              wdata_o <= {sh_q[14:0], mdio_s_i};
            end
          end
          default: state_q <= PBCR_IDLE;
        endcase
      end
    end
  end

  // read data driver, changes a few core clocks after mdc rises
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      dly_q <= '0;
      out_q <= '0;
      oe_q <= 1'b0;
      mdio_o <= 1'b0;
      mdio_oe_o <= 1'b0;
    end else begin
      dly_q <= {dly_q[PBCR_MDIO_OUT_DLY-1:0], rise};
      if (rd_o) out_q <= rdata_i;
      if (dly_q[PBCR_MDIO_OUT_DLY]) begin
        if (state_q == PBCR_TA && cnt_q == 4'h1 && mine_q && is_rd_q) begin
          oe_q <= 1'b1;
          mdio_oe_o <= 1'b1;
          mdio_o <= 1'b0;
        end else if (state_q == PBCR_DATA && oe_q) begin
          mdio_o <= out_q[15];
          out_q <= {out_q[14:0], 1'b0};
        end else begin
          oe_q <= 1'b0;
          mdio_oe_o <= 1'b0;
          mdio_o <= 1'b0;
        end
      end
    end
  end
endmodule : pbcr_mdio_slave

// *** logic/pbcr_top.sv ***
// phy basic control register with serial and host management access
// Behaviour
// - register sits at management index 0, sixteen bits wide
// - writing bit 15 resets phy registers except immune ones; self clears
// - bit 14 loops transmit data into receive path instead of network
// - with autoneg off, bit 13 picks 10 or 100 Mbps
// - bit 12 enables autoneg; negotiated result overrides forced speed, duplex
// - autoneg enable held zero while fiber mode setting is high
// - bit 11 puts the phy into general power down
// - writing one to bit 9 restarts autoneg; self clears; zero ignored; the one is ignored too while fiber mode setting is high
// - with autoneg off, bit 8 picks half or full duplex
// - bit 7 asserts collision during transmission
// - speed default is autoneg strap or speed strap; fiber gives one
// - autoneg enable default equals autoneg strap; fiber gives zero
// - copper duplex default is not autoneg strap and duplex strap
// - fiber duplex default equals duplex strap alone
// - reachable by host indirect access or serial pins at phy address
`timescale 1ns/1ps
module pbcr_top
  import pbcr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [PBCR_PHYAD_W-1:0] phy_addr_i,
  input wire logic autoneg_strap_i,
  input wire logic speed_strap_i,
  input wire logic duplex_strap_i,
  input wire logic fiber_mode_setting_i,
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_o,
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [PBCR_IDX_W-1:0] host_idx_i,
  input wire logic [PBCR_DATA_W-1:0] host_wdata_i,
  output logic [PBCR_DATA_W-1:0] host_rdata_o,
  output logic host_rvalid_o,
  output logic [PBCR_IDX_W-1:0] reg_idx_o,
  output logic [PBCR_DATA_W-1:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input wire logic [PBCR_DATA_W-1:0] reg_rdata_i,
  output logic soft_reset_o,
  output logic autoneg_restart_o,
  output logic near_loopback_o,
  output logic power_down_o,
  output logic autoneg_enable_o,
  output logic forced_speed_o,
  output logic forced_duplex_o,
  input wire logic an_done_i,
  input wire logic an_speed_i,
  input wire logic an_duplex_i,
  output logic link_speed_100_o,
  output logic link_full_duplex_o,
  input wire logic tx_active_i,
  output logic collision_o
);
  logic [1:0] pin_s;
  logic mdc_s;
  logic mdio_s;
  logic ser_wr;
  logic ser_rd;
  logic [PBCR_IDX_W-1:0] ser_idx;
  logic [PBCR_DATA_W-1:0] ser_wdata;
  logic [PBCR_DATA_W-1:0] rd_mux;
  logic [PBCR_DATA_W-1:0] ctrl_view;
  logic [PBCR_IDX_W-1:0] acc_idx;
  logic [PBCR_DATA_W-1:0] acc_wdata;
  logic acc_wr;
  logic acc_rd;
  logic hit;
  logic loop_q;
  logic speed_q;
  logic an_q;
  logic pdn_q;
  logic duplex_q;
  logic coltst_q;
  logic srst_q;
  logic rstan_q;
  logic fiber_s;
  logic [3:0] straps_s;
  logic def_speed;
  logic def_an;
  logic def_duplex;
  logic [1:0] init_q;

  pbcr_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .async_i({mdc_i, mdio_i}),
    .sync_o(pin_s)
  );
  assign mdc_s = pin_s[1];
  assign mdio_s = pin_s[0];

  pbcr_sync #(
    .WIDTH(4)
  ) u_strap_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .async_i({autoneg_strap_i, speed_strap_i, duplex_strap_i, fiber_mode_setting_i}),
    .sync_o(straps_s)
  );
  assign fiber_s = straps_s[0];

  pbcr_mdio_slave u_mdio (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .phy_addr_i(phy_addr_i),
    .mdc_s_i(mdc_s),
    .mdio_s_i(mdio_s),
    .mdio_o(mdio_o),
    .mdio_oe_o(mdio_oe_o),
    .wr_o(ser_wr),
    .rd_o(ser_rd),
    .idx_o(ser_idx),
    .wdata_o(ser_wdata),
    .rdata_i(rd_mux)
  );

  // straps decide the defaults
  assign def_speed = fiber_s ? 1'b1 : (straps_s[3] | straps_s[2]);
  assign def_an = fiber_s ? 1'b0 : straps_s[3];
  assign def_duplex = fiber_s ? straps_s[1]
    : (~straps_s[3] & straps_s[1]);

  // serial frames and host accesses share one port; host has priority
  assign acc_wr = host_wr_i | ser_wr;
  assign acc_rd = host_rd_i | ser_rd;
  assign acc_idx = (host_wr_i | host_rd_i) ? host_idx_i : ser_idx;
  assign acc_wdata = host_wr_i ? host_wdata_i : ser_wdata;
  assign hit = (acc_idx == PBCR_IDX_BASE_CTRL);

  // reserved bits read as zero, so writes to them are dropped
  assign ctrl_view = {srst_q, loop_q, speed_q, an_q, pdn_q, 1'b0, rstan_q,
    duplex_q, coltst_q, 7'h00} & PBCR_WR_MASK;
  assign rd_mux = hit ? ctrl_view : reg_rdata_i;

  // other registers live outside; soft reset is pulsed to them
  assign reg_idx_o = acc_idx;
  assign reg_wdata_o = acc_wdata;
  assign reg_wr_o = acc_wr & ~hit;
  assign reg_rd_o = acc_rd & ~hit;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      host_rdata_o <= '0;
      host_rvalid_o <= 1'b0;
    end else begin
      host_rvalid_o <= host_rd_i;
      if (host_rd_i) host_rdata_o <= rd_mux;
    end
  end

  // control bits; defaults loaded after reset and on soft reset
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      init_q <= 2'b11;
      loop_q <= 1'b0;
      speed_q <= 1'b0;
      an_q <= 1'b0;
      pdn_q <= 1'b0;
      duplex_q <= 1'b0;
      coltst_q <= 1'b0;
    end else if ((init_q != 2'b00) || srst_q) begin
      // three loads, so the strap synchroniser has filled by the last one
      if (init_q != 2'b00) init_q <= init_q - 2'b01;
      loop_q <= 1'b0;
      speed_q <= def_speed;
      an_q <= def_an;
      pdn_q <= 1'b0;
      duplex_q <= def_duplex;
      coltst_q <= 1'b0;
    end else begin
      if (acc_wr && hit) begin
        loop_q <= acc_wdata[PBCR_BIT_LOOP];
        speed_q <= acc_wdata[PBCR_BIT_SPEED];
        an_q <= acc_wdata[PBCR_BIT_AN] & ~fiber_s;
        pdn_q <= acc_wdata[PBCR_BIT_PDN];
        duplex_q <= acc_wdata[PBCR_BIT_DUPLEX];
        coltst_q <= acc_wdata[PBCR_BIT_COLTST];
      end else if (fiber_s) begin
        an_q <= 1'b0;
      end
    end
  end

  // self clearing bits: one cycle high after a write of one; the restart bit only while fiber mode setting is low
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      srst_q <= 1'b0;
      rstan_q <= 1'b0;
    end else begin
      srst_q <= acc_wr & hit & acc_wdata[PBCR_BIT_SRST];
      rstan_q <= acc_wr & hit & acc_wdata[PBCR_BIT_RSTAN] & ~fiber_s;
    end
  end

  assign soft_reset_o = srst_q;
  assign autoneg_restart_o = rstan_q;
  assign near_loopback_o = loop_q;
  assign power_down_o = pdn_q;
  assign autoneg_enable_o = an_q;
  assign forced_speed_o = speed_q;
  assign forced_duplex_o = duplex_q;

  // resolved link mode
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      link_speed_100_o <= 1'b0;
      link_full_duplex_o <= 1'b0;
      collision_o <= 1'b0;
    end else begin
      link_speed_100_o <= an_q ? (an_done_i & an_speed_i) : speed_q;
      link_full_duplex_o <= an_q ? (an_done_i & an_duplex_i) : duplex_q;
      collision_o <= coltst_q & tx_active_i;
    end
  end
endmodule : pbcr_top

// *** verification/pbcr_top_asserts.sv ***
// concurrent checks on the phy basic control register ports
`timescale 1ns/1ps
module pbcr_top_asserts
  import pbcr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic fiber_mode_setting_i,
  input wire logic host_wr_i,
  input wire logic host_rd_i,
  input wire logic [PBCR_IDX_W-1:0] host_idx_i,
  input wire logic [PBCR_DATA_W-1:0] host_wdata_i,
  input wire logic host_rvalid_o,
  input wire logic reg_rd_o,
  input wire logic soft_reset_o,
  input wire logic autoneg_restart_o,
  input wire logic near_loopback_o,
  input wire logic power_down_o,
  input wire logic autoneg_enable_o,
  input wire logic forced_speed_o,
  input wire logic forced_duplex_o,
  input wire logic an_done_i,
  input wire logic an_speed_i,
  input wire logic link_speed_100_o,
  input wire logic link_full_duplex_o,
  input wire logic tx_active_i,
  input wire logic collision_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  wire logic wr0 = host_wr_i && host_idx_i == PBCR_IDX_BASE_CTRL;
  a_rvalid_pulse: assert property (
    (host_rd_i ##1 !host_rd_i) |-> host_rvalid_o ##1 !host_rvalid_o)
    else $error("read answer not a single pulse");
  a_fwd_read: assert property (
    host_rd_i |-> reg_rd_o == (host_idx_i != PBCR_IDX_BASE_CTRL))
    else $error("read forwarding wrong");
  a_srst_pulse: assert property (
    wr0 && host_wdata_i[PBCR_BIT_SRST] |=> soft_reset_o ##1 !soft_reset_o)
    else $error("soft reset pulse wrong");
  a_rstan_clear: assert property (autoneg_restart_o |=> !autoneg_restart_o)
    else $error("restart does not self clear");
  a_rstan_zero: assert property (
    wr0 && !host_wdata_i[PBCR_BIT_RSTAN] |=> !autoneg_restart_o)
    else $error("restart without written one");
  a_loop_write: assert property (
    wr0 |=> near_loopback_o == $past(host_wdata_i[PBCR_BIT_LOOP]))
    else $error("loopback bit not written");
  a_pdn_write: assert property (
    wr0 |=> power_down_o == $past(host_wdata_i[PBCR_BIT_PDN]))
    else $error("power down bit not written");
  a_an_fiber: assert property (fiber_mode_setting_i [*5] |-> !autoneg_enable_o)
    else $error("autoneg enabled in fiber mode");
  a_speed_forced: assert property (
    !autoneg_enable_o |=> link_speed_100_o == $past(forced_speed_o))
    else $error("forced speed not applied");
  a_dup_forced: assert property (
    !autoneg_enable_o |=> link_full_duplex_o == $past(forced_duplex_o))
    else $error("forced duplex not applied");
  a_an_result: assert property (
    autoneg_enable_o && an_done_i |=> link_speed_100_o == $past(an_speed_i))
    else $error("negotiated speed not applied");
  a_coll_idle: assert property (!tx_active_i |=> !collision_o)
    else $error("collision without transmit");
  c_srst: cover property (soft_reset_o);
  c_rstan: cover property (autoneg_restart_o);
  c_coll: cover property (collision_o);
endmodule : pbcr_top_asserts

// *** verification/pbcr_far_model.sv ***
// model of the other phy registers and the autoneg engine
`timescale 1ns/1ps
module pbcr_far_model
  import pbcr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [PBCR_IDX_W-1:0] reg_idx_i,
  input wire logic [PBCR_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic autoneg_restart_i,
  output logic [PBCR_DATA_W-1:0] reg_rdata_o,
  output logic an_done_o,
  output logic an_speed_o,
  output logic an_duplex_o
);
  logic [PBCR_DATA_W-1:0] mem_q [32];
  logic [4:0] cnt_q;
  assign reg_rdata_o = mem_q[reg_idx_i];
  assign an_speed_o = an_done_o;
  assign an_duplex_o = an_done_o;
  always_ff @(posedge core_clk_i) begin
    if (reg_wr_i) begin
      mem_q[reg_idx_i] <= reg_wdata_i;
    end
  end
  // negotiation finishes 20 cycles after a restart
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cnt_q <= 5'h00;
      an_done_o <= 1'b0;
    end else if (autoneg_restart_i) begin
      cnt_q <= 5'h14;
      an_done_o <= 1'b0;
    end else begin
      if (cnt_q != 5'h00) cnt_q <= cnt_q - 5'h01;
      an_done_o <= an_done_o | (cnt_q == 5'h01);
    end
  end
endmodule : pbcr_far_model

// *** verification/phy_basic_control_register_test.sv ***
// self-checking bench for the phy basic control register
`timescale 1ns/1ps
module phy_basic_control_register_test;
  import pbcr_pkg::*;
  logic core_clk_i = 0, rst_n_i = 0, autoneg_strap_i = 0, speed_strap_i = 0;
  logic duplex_strap_i = 0, fiber_mode_setting_i = 0, mdc_i = 0, mdio_d = 1;
  logic host_wr_i = 0, host_rd_i = 0, tx_active_i = 0;
  logic [4:0] phy_addr_i = 5'h03, host_idx_i = 5'h00, reg_idx_o;
  logic [15:0] host_wdata_i = 16'h0000, host_rdata_o, reg_wdata_o, reg_rdata_i;
  logic mdio_o, mdio_oe_o, host_rvalid_o, reg_wr_o, reg_rd_o, soft_reset_o;
  logic autoneg_restart_o, near_loopback_o, power_down_o, autoneg_enable_o;
  logic forced_speed_o, forced_duplex_o, an_done_i, an_speed_i, an_duplex_i;
  logic link_speed_100_o, link_full_duplex_o, collision_o;
  wire mdio_i = mdio_oe_o ? mdio_o : mdio_d;
  logic mdio_smp;
  int n_fail = 0, cmp_count = 0;
  // straps an sp dx fx, then expected speed, autoneg, duplex
  logic [6:0] rows [6] = '{7'h00, 7'h35, 7'h56, 7'h11, 7'h5D, 7'h0C};
  pbcr_top dut (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .phy_addr_i(phy_addr_i),
    .autoneg_strap_i(autoneg_strap_i),
    .speed_strap_i(speed_strap_i),
    .duplex_strap_i(duplex_strap_i),
    .fiber_mode_setting_i(fiber_mode_setting_i),
    .mdc_i(mdc_i),
    .mdio_i(mdio_i),
    .mdio_o(mdio_o),
    .mdio_oe_o(mdio_oe_o),
    .host_wr_i(host_wr_i),
    .host_rd_i(host_rd_i),
    .host_idx_i(host_idx_i),
    .host_wdata_i(host_wdata_i),
    .host_rdata_o(host_rdata_o),
    .host_rvalid_o(host_rvalid_o),
    .reg_idx_o(reg_idx_o),
    .reg_wdata_o(reg_wdata_o),
    .reg_wr_o(reg_wr_o),
    .reg_rd_o(reg_rd_o),
    .reg_rdata_i(reg_rdata_i),
    .soft_reset_o(soft_reset_o),
    .autoneg_restart_o(autoneg_restart_o),
    .near_loopback_o(near_loopback_o),
    .power_down_o(power_down_o),
    .autoneg_enable_o(autoneg_enable_o),
    .forced_speed_o(forced_speed_o),
    .forced_duplex_o(forced_duplex_o),
    .an_done_i(an_done_i),
    .an_speed_i(an_speed_i),
    .an_duplex_i(an_duplex_i),
    .link_speed_100_o(link_speed_100_o),
    .link_full_duplex_o(link_full_duplex_o),
    .tx_active_i(tx_active_i),
    .collision_o(collision_o)
  );
  pbcr_far_model far (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .reg_idx_i(reg_idx_o),
    .reg_wdata_i(reg_wdata_o),
    .reg_wr_i(reg_wr_o),
    .autoneg_restart_i(autoneg_restart_o),
    .reg_rdata_o(reg_rdata_i),
    .an_done_o(an_done_i),
    .an_speed_o(an_speed_i),
    .an_duplex_o(an_duplex_i)
  );
  initial begin
    forever #20 core_clk_i = ~core_clk_i;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : tick
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic hwr(input logic [4:0] idx, input logic [15:0] d);
    host_wr_i = 1;
    host_idx_i = idx;
    host_wdata_i = d;
    tick(1);
    host_wr_i = 0;
  endtask : hwr
  task automatic hrd(input logic [4:0] idx, input logic [15:0] exp);
    host_rd_i = 1;
    host_idx_i = idx;
    tick(1);
    host_rd_i = 0;
    chk("rvalid", 16'h0001, {15'h0000, host_rvalid_o});
    chk("rdata", exp, host_rdata_o);
  endtask : hrd
  task automatic mbit(input logic b);
    mdio_d = b;
    tick(5);
    mdio_smp = mdio_i;
    mdc_i = 1;
    tick(5);
    mdc_i = 0;
  endtask : mbit
  task automatic mwr(input logic [4:0] pa, input logic [15:0] d);
    logic [31:0] f;
    f = {PBCR_ST_START, PBCR_OP_WRITE, pa, PBCR_IDX_BASE_CTRL, PBCR_TA_WRITE, d};
    repeat (64) mbit(1);
    for (int i = 31; i >= 0; i--) mbit(f[i]);
    mdio_d = 1;
    tick(12);
  endtask : mwr
  task automatic mrd(input logic [4:0] pa, input logic [15:0] exp);
    logic [13:0] h;
    logic [15:0] got;
    h = {PBCR_ST_START, PBCR_OP_READ, pa, PBCR_IDX_BASE_CTRL};
    repeat (64) mbit(1);
    for (int i = 13; i >= 0; i--) mbit(h[i]);
    mbit(1);
    mbit(1);
    chk("ta_drive", 16'h0002, {14'h0000, mdio_oe_o, mdio_smp});
    for (int i = 15; i >= 0; i--) begin
      mbit(1);
      got[i] = mdio_smp;
    end
    mdio_d = 1;
    tick(12);
    chk("mdio_rd", exp, got);
    chk("mdio_rel", 16'h0000, {15'h0000, mdio_oe_o});
  endtask : mrd
  task automatic wrap_up();
    $display("checks %0d failures %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up
  initial begin
    #1000000;
    n_fail++;
    wrap_up();
  end
  initial begin
    logic [15:0] e;
    tick(5);
    chk("reset", 16'h0000, {8'h00, near_loopback_o, power_down_o, autoneg_enable_o,
        forced_speed_o, forced_duplex_o, collision_o, soft_reset_o, host_rvalid_o});
    rst_n_i = 1;
    tick(4);
    foreach (rows[i]) begin
      {autoneg_strap_i, speed_strap_i, duplex_strap_i, fiber_mode_setting_i} = rows[i][6:3];
      e = {2'h0, rows[i][2:1], 3'h0, rows[i][0], 8'h00};
      tick(4);
      hwr(5'h00, 16'h8000);
      chk("srst", 16'h0001, {15'h0000, soft_reset_o});
      tick(2);
      chk("dflt", e,
          {2'h0, forced_speed_o, autoneg_enable_o, 3'h0, forced_duplex_o, 8'h00});
      hrd(5'h00, e);
    end
    hwr(5'h00, 16'h1000);
    tick(1);
    chk("an_fiber", 16'h0000, {15'h0000, autoneg_enable_o});
    hrd(5'h00, 16'h0000);
    fiber_mode_setting_i = 0;
    duplex_strap_i = 0;
    tick(4);
    hwr(5'h00, 16'h4980);
    tx_active_i = 1;
    tick(3);
    chk("ctl", 16'h000F,
        {12'h000, near_loopback_o, power_down_o, forced_duplex_o, collision_o});
    chk("link", 16'h0001, {14'h0000, link_speed_100_o, link_full_duplex_o});
    tx_active_i = 0;
    hrd(5'h00, 16'h4980);
    hwr(5'h00, 16'h1200);
    chk("rstan", 16'h0001, {15'h0000, autoneg_restart_o});
    tick(30);
    chk("an_res", 16'h0003, {14'h0000, link_speed_100_o, link_full_duplex_o});
    hrd(5'h00, 16'h1000);
    hwr(5'h05, 16'h5A5A);
    hrd(5'h05, 16'h5A5A);
    mwr(5'h04, 16'h0000);
    hrd(5'h00, 16'h1000);
    mwr(5'h03, 16'h2100);
    hrd(5'h00, 16'h2100);
    mrd(5'h03, 16'h2100);
    {autoneg_strap_i, speed_strap_i, duplex_strap_i} = 3'b101;
    rst_n_i = 0;
    tick(5);
    rst_n_i = 1;
    tick(4);
    chk("por", 16'h3000,
        {2'h0, forced_speed_o, autoneg_enable_o, 3'h0, forced_duplex_o, 8'h00});
    wrap_up();
  end
endmodule : phy_basic_control_register_test
bind pbcr_top pbcr_top_asserts u_chk (
  .core_clk_i(core_clk_i),
  .rst_n_i(rst_n_i),
  .fiber_mode_setting_i(fiber_mode_setting_i),
  .host_wr_i(host_wr_i),
  .host_rd_i(host_rd_i),
  .host_idx_i(host_idx_i),
  .host_wdata_i(host_wdata_i),
  .host_rvalid_o(host_rvalid_o),
  .reg_rd_o(reg_rd_o),
  .soft_reset_o(soft_reset_o),
  .autoneg_restart_o(autoneg_restart_o),
  .near_loopback_o(near_loopback_o),
  .power_down_o(power_down_o),
  .autoneg_enable_o(autoneg_enable_o),
  .forced_speed_o(forced_speed_o),
  .forced_duplex_o(forced_duplex_o),
  .an_done_i(an_done_i),
  .an_speed_i(an_speed_i),
  .link_speed_100_o(link_speed_100_o),
  .link_full_duplex_o(link_full_duplex_o),
  .tx_active_i(tx_active_i),
  .collision_o(collision_o)
);
